// ---- logic/sfc_pkg.sv ----
// What this block does
// - trigger at power-up inverts stored host mode
// - keyboard mode ignores host commands; host lamp control still acts
// - two indicators, each red, green or yellow
// - upper shows scanning, lower shows read result
// - scanning indicator dark while trigger released
// - scanning green until read result (pass or fail) or release
// - read indicator green pass, red fail, holds
// - press darkens read indicator until next read result, release or not
// - host control sets indicators directly
// - power-on low beep on reader module error
// - beep per good read, enable set after reset
// - forward read data at once after success
// - new scan only after release and re-pull
// - keep scanning until read or release
`default_nettype none
package sfc_pkg;
    localparam logic [1:0] LED_OFF    = 2'h0;
    localparam logic [1:0] LED_GREEN  = 2'h1;
    localparam logic [1:0] LED_RED    = 2'h2;
    localparam logic [1:0] LED_YELLOW = 2'h3;
    localparam logic       MODE_SERIAL = 1'h0;
    localparam logic       MODE_KBD    = 1'h1;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned BEEP_MS     = 100;
    localparam int unsigned ERR_BEEP_MS = 500;
    localparam int unsigned BEEP_CYC    = CLK_HZ / 1000 * BEEP_MS;
    localparam int unsigned ERR_CYC     = CLK_HZ / 1000 * ERR_BEEP_MS;
    localparam int unsigned ERR_TONE_HZ = 500;
    localparam int unsigned OK_TONE_HZ  = 2000;
    localparam int unsigned ERR_HALF    = CLK_HZ / ERR_TONE_HZ / 2;
    localparam int unsigned OK_HALF     = CLK_HZ / OK_TONE_HZ / 2;
    localparam int unsigned CW          = 26;
    localparam logic [CW-1:0] CNT_ZERO  = 26'h0;
    localparam logic [CW-1:0] CNT_ONE   = 26'h1;

    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_IDLE    = 2'b01,
        ST_SCAN    = 2'b10,
        ST_DONE    = 2'b11
    } sfc_state_t;
endpackage
`default_nettype wire

// ---- logic/sfc_scan_feedback_control.sv ----
`default_nettype none
module sfc_scan_feedback_control #(
    parameter int unsigned BEEP_CYCLES     = sfc_pkg::BEEP_CYC,
    parameter int unsigned ERR_BEEP_CYCLES = sfc_pkg::ERR_CYC,
    parameter int unsigned OK_HALF_CYCLES  = sfc_pkg::OK_HALF,
    parameter int unsigned ERR_HALF_CYCLES = sfc_pkg::ERR_HALF
) (
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       TRIGGER_I,
    input  wire logic       STORED_MODE_I,
    input  wire logic       READER_ERR_I,
    input  wire logic       BEEP_EN_WR_I,
    input  wire logic       BEEP_EN_VAL_I,
    input  wire logic       READ_DONE_I,
    input  wire logic       READ_PASS_I,
    input  wire logic [7:0] READ_DATA_I,
    input  wire logic       HOST_CTRL_I,
    input  wire logic [1:0] HOST_LED_TOP_I,
    input  wire logic [1:0] HOST_LED_BOT_I,
    input  wire logic       HOST_CMD_VALID_I,
    input  wire logic [7:0] HOST_CMD_I,
    output logic            HOST_MODE_O,
    output logic            MODE_WR_O,
    output logic            MODE_WR_VAL_O,
    output logic            SCAN_EN_O,
    output logic [1:0]      LED_TOP_O,
    output logic [1:0]      LED_BOT_O,
    output logic            BEEP_O,
    output logic            BEEP_EN_O,
    output logic            FWD_VALID_O,
    output logic [7:0]      FWD_DATA_O,
    output logic            CMD_VALID_O,
    output logic [7:0]      CMD_O
);
    localparam int unsigned CW = sfc_pkg::CW;

    typedef struct packed {
        sfc_pkg::sfc_state_t st;
        logic                host_mode;
        logic                mode_wr;
        logic                beep_en;
        logic [1:0]          led_top;
        logic [1:0]          led_bot;
        logic [CW-1:0]       beep_cnt;
        logic [CW-1:0]       tone_cnt;
        logic                tone_err;
        logic                beep;
        logic                fwd_valid;
        logic [7:0]          fwd_data;
        logic                cmd_valid;
        logic [7:0]          cmd;
    } sfc_regs_t;

    sfc_regs_t s_r;
    sfc_regs_t s_nxt;
    logic      beep_busy;

    assign beep_busy = (s_r.beep_cnt != sfc_pkg::CNT_ZERO);

    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.mode_wr   = 1'b0;
        s_nxt.fwd_valid = 1'b0;
        s_nxt.cmd_valid = 1'b0;
        if (BEEP_EN_WR_I)
        begin
            s_nxt.beep_en = BEEP_EN_VAL_I;
        end
        // commands pass only in serial mode; keyboard mode drops them
        if (HOST_CMD_VALID_I
            && s_r.host_mode == sfc_pkg::MODE_SERIAL)
        begin
            s_nxt.cmd_valid = 1'b1;
            s_nxt.cmd       = HOST_CMD_I;
        end
        case (s_r.st)
            sfc_pkg::ST_POWERUP:
            begin
                // the trigger level is caught after reset release
                if (TRIGGER_I)
                begin
                    s_nxt.host_mode = ~STORED_MODE_I;
                    s_nxt.mode_wr   = 1'b1;
                end
                else
                begin
                    s_nxt.host_mode = STORED_MODE_I;
                end
                if (READER_ERR_I)
                begin
                    s_nxt.beep_cnt = CW'(ERR_BEEP_CYCLES);
                    s_nxt.tone_err = 1'b1;
                    s_nxt.tone_cnt = sfc_pkg::CNT_ZERO;
                end
                // a pull held through power-up must be released first
                s_nxt.st = TRIGGER_I ? sfc_pkg::ST_DONE : sfc_pkg::ST_IDLE;
            end
            sfc_pkg::ST_IDLE:
            begin
                s_nxt.led_top = sfc_pkg::LED_OFF;
                if (TRIGGER_I)
                begin
                    s_nxt.st      = sfc_pkg::ST_SCAN;
                    s_nxt.led_top = sfc_pkg::LED_GREEN;
                    s_nxt.led_bot = sfc_pkg::LED_OFF;
                end
            end
            sfc_pkg::ST_SCAN:
            begin
                if (!TRIGGER_I)
                begin
                    s_nxt.st      = sfc_pkg::ST_IDLE;
                    s_nxt.led_top = sfc_pkg::LED_OFF;
                end
                else if (READ_DONE_I)
                begin
                    s_nxt.st      = sfc_pkg::ST_DONE;
                    s_nxt.led_top = sfc_pkg::LED_OFF;
                    s_nxt.led_bot = READ_PASS_I ? sfc_pkg::LED_GREEN
                                                : sfc_pkg::LED_RED;
                    if (READ_PASS_I)
                    begin
                        s_nxt.fwd_valid = 1'b1;
                        s_nxt.fwd_data  = READ_DATA_I;
                        if (s_r.beep_en)
                        begin
                            s_nxt.beep_cnt = CW'(BEEP_CYCLES);
                            s_nxt.tone_err = 1'b0;
                            s_nxt.tone_cnt = sfc_pkg::CNT_ZERO;
                        end
                    end
                end
            end
            sfc_pkg::ST_DONE:
            begin
                s_nxt.led_top = sfc_pkg::LED_OFF;
                if (!TRIGGER_I)
                begin
                    s_nxt.st = sfc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = sfc_pkg::ST_IDLE;
            end
        endcase
        // square-wave tone; pitch picks error or success sound
        if (beep_busy)
        begin
            s_nxt.beep_cnt = s_nxt.beep_cnt - sfc_pkg::CNT_ONE;
            if (s_r.tone_cnt == sfc_pkg::CNT_ZERO)
            begin
                s_nxt.tone_cnt = s_r.tone_err ? CW'(ERR_HALF_CYCLES - 1)
                                              : CW'(OK_HALF_CYCLES - 1);
                s_nxt.beep     = ~s_r.beep;
            end
            else
            begin
                s_nxt.tone_cnt = s_r.tone_cnt - sfc_pkg::CNT_ONE;
            end
        end
        else
        begin
            s_nxt.beep = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            s_r           <= '0;
            s_r.st        <= sfc_pkg::ST_POWERUP;
            s_r.beep_en   <= 1'b1;
            s_r.host_mode <= sfc_pkg::MODE_SERIAL;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign HOST_MODE_O   = s_r.host_mode;
    assign MODE_WR_O     = s_r.mode_wr;
    assign MODE_WR_VAL_O = s_r.host_mode;
    assign SCAN_EN_O     = (s_r.st == sfc_pkg::ST_SCAN);
    // host override of both lamps, any of the four codes
    assign LED_TOP_O     = HOST_CTRL_I ? HOST_LED_TOP_I
                                       : s_r.led_top;
    assign LED_BOT_O     = HOST_CTRL_I ? HOST_LED_BOT_I
                                       : s_r.led_bot;
    assign BEEP_O        = s_r.beep;
    assign BEEP_EN_O     = s_r.beep_en;
    assign FWD_VALID_O   = s_r.fwd_valid;
    assign FWD_DATA_O    = s_r.fwd_data;
    assign CMD_VALID_O   = s_r.cmd_valid;
    assign CMD_O         = s_r.cmd;

    property p_toggle;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        // the release edge still sees reset state, so qualify on reset
        (RST_N_I && s_r.st == sfc_pkg::ST_POWERUP && TRIGGER_I)
            |=> (MODE_WR_O && HOST_MODE_O == !$past(STORED_MODE_I));
    endproperty
    mode_toggle_a: assert property (p_toggle)
        else $error("power-up toggle wrong");

    kbd_no_cmd_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        ($past(s_r.host_mode) == sfc_pkg::MODE_KBD) |-> !CMD_VALID_O)
        else $error("command passed in keyboard mode");

    top_dark_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!HOST_CTRL_I && s_r.st == sfc_pkg::ST_IDLE && !TRIGGER_I)
            |=> (HOST_CTRL_I || LED_TOP_O == sfc_pkg::LED_OFF))
        else $error("scan lamp lit without trigger");

    sequence s_press;
        s_r.st == sfc_pkg::ST_IDLE && TRIGGER_I;
    endsequence
    press_lamps_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_press |=> (s_r.led_top == sfc_pkg::LED_GREEN
                     && s_r.led_bot == sfc_pkg::LED_OFF && SCAN_EN_O))
        else $error("press lamps wrong");

    read_color_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (SCAN_EN_O && TRIGGER_I && READ_DONE_I)
            |=> s_r.led_bot == ($past(READ_PASS_I) ? sfc_pkg::LED_GREEN
                                                  : sfc_pkg::LED_RED))
        else $error("read lamp colour wrong");

    fwd_read_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (SCAN_EN_O && TRIGGER_I && READ_DONE_I && READ_PASS_I)
            |=> (FWD_VALID_O && FWD_DATA_O == $past(READ_DATA_I)))
        else $error("read data not forwarded");

    no_rescan_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (s_r.st == sfc_pkg::ST_DONE && TRIGGER_I) |=> !SCAN_EN_O)
        else $error("scan restarted without release");

    beep_start_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (SCAN_EN_O && TRIGGER_I && READ_DONE_I && READ_PASS_I && BEEP_EN_O
            && !BEEP_EN_WR_I) |=> ##1 BEEP_O)
        else $error("no beep on good read");

    host_led_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        HOST_CTRL_I |-> (LED_TOP_O == HOST_LED_TOP_I
                         && LED_BOT_O == HOST_LED_BOT_I))
        else $error("host lamp control ignored");

    mode_keep_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RST_N_I && s_r.st == sfc_pkg::ST_POWERUP && !TRIGGER_I)
            |=> (!MODE_WR_O && HOST_MODE_O == $past(STORED_MODE_I)))
        else $error("stored mode not kept");

    mode_wr_once_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        MODE_WR_O |=> (!MODE_WR_O
                       && MODE_WR_VAL_O == $past(MODE_WR_VAL_O)))
        else $error("mode write not a single pulse");

    sequence s_err_start;
        RST_N_I && s_r.st == sfc_pkg::ST_POWERUP && READER_ERR_I;
    endsequence
    err_beep_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_err_start |=> !BEEP_O ##1 BEEP_O)
        else $error("no error beep at power-on");

    scan_green_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        SCAN_EN_O |-> s_r.led_top == sfc_pkg::LED_GREEN)
        else $error("scan lamp not green while scanning");

    top_off_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !SCAN_EN_O |-> s_r.led_top == sfc_pkg::LED_OFF)
        else $error("scan lamp lit while not scanning");

    release_stop_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (SCAN_EN_O && !TRIGGER_I) |=> !SCAN_EN_O)
        else $error("scan kept after release");

    scan_keep_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (SCAN_EN_O && TRIGGER_I && !READ_DONE_I) |=> SCAN_EN_O)
        else $error("scan stopped while trigger held");

    bot_hold_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (s_r.st == sfc_pkg::ST_DONE) |=> $stable(s_r.led_bot))
        else $error("read lamp changed before press");

    cmd_pass_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RST_N_I && HOST_CMD_VALID_I && HOST_MODE_O == sfc_pkg::MODE_SERIAL)
            |=> (CMD_VALID_O && CMD_O == $past(HOST_CMD_I)))
        else $error("serial command not passed");

    fwd_cause_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        FWD_VALID_O |-> ($past(READ_DONE_I) && $past(READ_PASS_I)))
        else $error("data forwarded without good read");
endmodule // sfc_scan_feedback_control
`default_nettype wire

// ---- test/scan_feedback_control_bench.sv ----
`default_nettype none
module scan_feedback_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, trig = 0, stored = 0, err = 0, bew = 0;
    logic bev = 0, done, pass, hctl = 0, cmdv = 0, pcfg = 1, got;
    logic [7:0] data, cmd = 8'h0, dly = 8'h3, dcfg = 8'h0;
    logic [1:0] htop = 2'h0, hbot = 2'h0, top, bot;
    logic mode, mwr, mwv, scan, beep, been, fwdv, cmdov;
    logic [7:0] fwd, cmdo;
    int n_fail = 0, comparisons = 0;
    sfc_scan_feedback_control #(.BEEP_CYCLES(20), .ERR_BEEP_CYCLES(40),
        .OK_HALF_CYCLES(2), .ERR_HALF_CYCLES(4)) dut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .TRIGGER_I(trig),
        .STORED_MODE_I(stored), .READER_ERR_I(err), .BEEP_EN_WR_I(bew),
        .BEEP_EN_VAL_I(bev), .READ_DONE_I(done), .READ_PASS_I(pass),
        .READ_DATA_I(data), .HOST_CTRL_I(hctl), .HOST_LED_TOP_I(htop),
        .HOST_LED_BOT_I(hbot), .HOST_CMD_VALID_I(cmdv), .HOST_CMD_I(cmd),
        .HOST_MODE_O(mode), .MODE_WR_O(mwr), .MODE_WR_VAL_O(mwv),
        .SCAN_EN_O(scan), .LED_TOP_O(top), .LED_BOT_O(bot), .BEEP_O(beep),
        .BEEP_EN_O(been), .FWD_VALID_O(fwdv), .FWD_DATA_O(fwd),
        .CMD_VALID_O(cmdov), .CMD_O(cmdo));
    sfc_reader_model rdr (.clk_i(clk), .rst_n_i(rst_n), .scan_en_i(scan),
        .delay_i(dly), .pass_cfg_i(pcfg), .data_cfg_i(dcfg),
        .done_o(done), .pass_o(pass), .data_o(data));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: sig = fwdv;
            1: sig = beep;
            default: sig = mwr;
        endcase
    endfunction
    task automatic wait_for(input int w, input int lim);
        got = 0;
        repeat (lim)
        begin
            @(posedge clk);
            #1;
            if (sig(w) === 1'b1)
            begin
                got = 1;
                break;
            end
        end
    endtask
    task automatic do_reset(input logic t, input logic s, input logic e);
        @(posedge clk) {rst_n, trig, stored, err} <= {1'b0, t, s, e};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic drive(input logic t, input int n);
        @(posedge clk) trig <= t;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send_cmd(input logic [7:0] c, input logic exp_v);
        @(posedge clk) {cmdv, cmd} <= {1'b1, c};
        @(posedge clk) cmdv <= 1'b0;
        #1;
        chk(8'(cmdov), 8'(exp_v));
        if (exp_v)
            chk(cmdo, c);
    endtask
    task automatic summarize;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #60000;
        n_fail++;
        summarize;
    end
    initial
    begin
        do_reset(1'b0, 1'b1, 1'b1);
        wait_for(1, 12);
        chk(8'(got), 8'h1);
        chk(8'(been), 8'h1);
        chk(8'(mode), 8'(sfc_pkg::MODE_KBD));
        send_cmd(8'h5a, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            do_reset(1'b1, s[0], 1'b0);
            wait_for(2, 4);
            chk(8'(got), 8'h1);
            chk(8'(mwv), 8'(!s[0]));
            chk(8'(mode), 8'(!s[0]));
            drive(1'b0, 3);
        end
        send_cmd(8'ha7, 1'b1);
        dcfg <= 8'hc3;
        drive(1'b1, 1);
        chk({scan, 3'h0, top, bot}, 8'h84);
        wait_for(0, 20);
        chk(fwd, 8'hc3);
        chk({scan, 3'h0, top, bot}, 8'h01);
        wait_for(1, 3);
        chk(8'(got), 8'h1);
        repeat (10) @(posedge clk);
        #1;
        chk(8'({scan, fwdv}), 8'h0);
        drive(1'b0, 2);
        chk(8'({top, bot}), 8'h01);
        pcfg <= 1'b0;
        drive(1'b1, 1);
        chk(8'({top, bot}), 8'h04);
        repeat (10) @(posedge clk);
        #1;
        chk({beep,fwdv,scan,1'b0,top,bot}, 8'(sfc_pkg::LED_RED));
        drive(1'b0, 2);
        @(posedge clk) {bew, bev, pcfg} <= 3'b101;
        @(posedge clk) bew <= 1'b0;
        drive(1'b1, 1);
        chk(8'(been), 8'h0);
        wait_for(0, 20);
        wait_for(1, 6);
        chk(8'(got), 8'h0);
        drive(1'b0, 2);
        dly <= 8'hc8;
        drive(1'b1, 4);
        chk(8'({scan, top}), 8'h05);
        drive(1'b0, 2);
        chk({scan, 3'h0, top, bot}, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clk) {hctl, htop, hbot} <= {1'b1, 2'(c), 2'(3 - c)};
            @(posedge clk) #1;
            chk(8'({top, bot}), 8'({2'(c), 2'(3 - c)}));
        end
        @(posedge clk) hctl <= 1'b0;
        summarize;
    end
endmodule // scan_feedback_control_bench
`default_nettype wire

// ---- test/sfc_reader_model.sv ----
`default_nettype none
module sfc_reader_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scan_en_i,
    input  wire logic [7:0] delay_i,
    input  wire logic       pass_cfg_i,
    input  wire logic [7:0] data_cfg_i,
    output logic            done_o,
    output logic            pass_o,
    output logic [7:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic       fired_r;
    // one result per scan; between results the lines churn so that
    // nothing stale can pass for a fresh read
    always_ff @(posedge clk_i)
    begin
        done_o <= 1'b0;
        pass_o <= ~pass_o;
        data_o <= ~data_o;
        if (!rst_n_i)
        begin
            pass_o <= 1'b0;
            data_o <= 8'h0;
        end
        if (!rst_n_i || !scan_en_i)
        begin
            cnt_r   <= 8'h0;
            fired_r <= 1'b0;
        end
        else if (!fired_r && cnt_r == delay_i)
        begin
            done_o  <= 1'b1;
            pass_o  <= pass_cfg_i;
            data_o  <= data_cfg_i;
            fired_r <= 1'b1;
        end
        else if (!fired_r)
            cnt_r <= cnt_r + 8'h1;
    end
endmodule // sfc_reader_model
`default_nettype wire
